// File: sac_map.vh
// Purpose: register map and constants for the SAR converter control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: all offsets are byte addresses
`ifndef SAC_MAP_VH
`define SAC_MAP_VH
`define SAC_OFF_CONTROL 12'h000
`define SAC_OFF_SELECT 12'h004
`define SAC_OFF_CONFIG 12'h008
`define SAC_OFF_RES_HIGH 12'h00C
`define SAC_OFF_RES_LOW 12'h010
`define SAC_OFF_STATUS 12'h014
`define SAC_CTL_ENABLE 0
`define SAC_CTL_START 1
`define SAC_CFG_GAIN_LO 0
`define SAC_CFG_GAIN_HI 1
`define SAC_CFG_COMPAT 2
`define SAC_SEL_TEMP 4'h8
`define SAC_SEL_SUPPLY 4'h9
`define SAC_SEL_LAST 4'h9
`define SAC_GAIN_1X 2'h1
`define SAC_GAIN_HALF 2'h0
`define SAC_BITS_FULL 4'hA
`define SAC_BITS_COMPAT 4'h8
`define SAC_RESET_SELECT 4'h0
`define SAC_RESET_GAIN 2'h1
`endif

// File: sac_sar.v
// Purpose: successive-approximation sequencer, one bit per step
// Assumes: comparator answer valid the cycle after a trial code
// Notes: compat mode stops after the upper eight bits
`timescale 1ns/1ps
`include "sac_map.vh"
module sac_sar (
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    input wire start,
    input wire compat,
    input wire cmp_high,
    output reg [9:0] trial,
    output reg busy,
    output reg done,
    output reg [9:0] code
);
    reg [3:0] step;
    reg settle;
    wire [3:0] last_step;
    assign last_step = compat ? `SAC_BITS_COMPAT : `SAC_BITS_FULL;

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trial <= 10'h000;
            busy <= 1'b0;
            done <= 1'b0;
            code <= 10'h000;
            step <= 4'h0;
            settle <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            if (!busy) begin
                if (start) begin
                    busy <= 1'b1;
                    step <= 4'h0;
                    settle <= 1'b0;
                    trial <= 10'h200;
                end
            end else if (!settle) begin
                // Trial code reaches the DAC one cycle late; wait for it
                settle <= 1'b1;
            end else begin
                settle <= 1'b0;
                // Keep or drop the bit under trial, then try the next one
                if (!cmp_high)
                    trial[4'h9 - step] <= 1'b0;
                if (step + 4'h1 == last_step) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    code <= cmp_high ? trial :
                        (trial & ~(10'h200 >> step));
                    if (compat)
                        code[1:0] <= 2'h0;
                end else begin
                    step <= step + 4'h1;
                    trial[4'h8 - step] <= 1'b1;
                end
            end
        end
    end
endmodule

// File: sac_top.v
// Purpose: control side of a 10-bit SAR converter behind APB
// Assumes: analog front end answers cmp_high for the current trial code
// Notes: one clock, zero wait states
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "sac_map.vh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Converter runs only while enable is 1; a conversion under way when enable drops still finishes
// - Enable 0 keeps shutdown, no conversions; new starts are blocked and dac_code is held at zero
// - Ten input sources, negative input is ground
// - Any port pin routable to positive input
// - Temperature sensor or supply also selectable
// - Two-bit field selects gain 1x or 0.5x
// - Half gain full scale equals twice reference
// - Result is 10-bit unsigned code
// - Left-justified across high and low bytes
// - Eight-bit compatibility mode is offered
// - Compat mode: low two bits zero
// - Compat conversion two steps shorter
module sac_top (
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire cmp_high,
    output reg [9:0] dac_code,
    output reg [3:0] mux_select,
    output reg gain_half,
    output reg shutdown
);
    //////////////////////////////////////////////////////////////////////////
    reg enable;
    reg [1:0] gain_sel;
    reg compat;
    reg [7:0] res_high;
    reg [7:0] res_low;
    reg start_req;
    wire [9:0] trial;
    wire busy;
    wire done;
    wire [9:0] code;
    wire wr;
    wire rd;
    wire mapped;

    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && !penable && !pwrite;
    assign mapped = (paddr == `SAC_OFF_CONTROL) ||
        (paddr == `SAC_OFF_SELECT) || (paddr == `SAC_OFF_CONFIG) ||
        (paddr == `SAC_OFF_RES_HIGH) || (paddr == `SAC_OFF_RES_LOW) ||
        (paddr == `SAC_OFF_STATUS);

    sac_sar u_sar (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .start(start_req && enable && !done),
        .compat(compat),
        .cmp_high(cmp_high),
        .trial(trial),
        .busy(busy),
        .done(done),
        .code(code)
    );

    //////////////////////////////////////////////////////////////////////////
    // Bus slave: one setup, one access cycle, read data ready at access
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable <= 1'b0;
            mux_select <= `SAC_RESET_SELECT;
            gain_sel <= `SAC_RESET_GAIN;
            compat <= 1'b0;
            start_req <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (busy || !enable)
                start_req <= 1'b0;
            if (rd) begin
                case (paddr)
                `SAC_OFF_CONTROL: prdata <= {30'h0, start_req, enable};
                `SAC_OFF_SELECT: prdata <= {28'h0, mux_select};
                `SAC_OFF_CONFIG: prdata <= {29'h0, compat, gain_sel};
                `SAC_OFF_RES_HIGH: prdata <= {24'h0, res_high};
                `SAC_OFF_RES_LOW: prdata <= {24'h0, res_low};
                `SAC_OFF_STATUS: prdata <= {31'h0, busy};
                default: prdata <= 32'h00000000;
                endcase
            end
            if (wr) begin
                case (paddr)
                `SAC_OFF_CONTROL: begin
                    enable <= pwdata[`SAC_CTL_ENABLE];
                    start_req <= pwdata[`SAC_CTL_START] &&
                        pwdata[`SAC_CTL_ENABLE];
                end
                `SAC_OFF_SELECT: begin
                    // Out-of-range codes are ignored; ten sources only
                    if (pwdata[3:0] <= `SAC_SEL_LAST)
                        mux_select <= pwdata[3:0];
                end
                `SAC_OFF_CONFIG: begin
                    gain_sel <= pwdata[`SAC_CFG_GAIN_HI:`SAC_CFG_GAIN_LO];
                    compat <= pwdata[`SAC_CFG_COMPAT];
                end
                default: ;
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Analog-side drive and result capture
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            res_high <= 8'h00;
            res_low <= 8'h00;
            dac_code <= 10'h000;
            gain_half <= 1'b0;
            shutdown <= 1'b1;
        end else if (clk_en) begin
            shutdown <= !enable;
            // Half gain doubles the input span seen at full scale
            gain_half <= (gain_sel == `SAC_GAIN_HALF);
            dac_code <= enable ? trial : 10'h000;
            if (done) begin
                res_high <= code[9:2];
                res_low <= {code[1:0], 6'h00};
            end
        end
    end
endmodule

// File: sac_props.sv
// Purpose: port checks for the converter control block
// Assumes: clk_en held high
// Notes: bound into sac_top
`timescale 1ns/1ps
module sac_props (
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire cmp_high,
    input wire [9:0] dac_code,
    input wire [3:0] mux_select,
    input wire gain_half,
    input wire shutdown
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!reset_n);
wire wr = psel && penable && pready && pwrite;
a_ready_zero_wait: assert property (psel && !penable ##1 clk_en |-> pready)
    else $error("no ready after setup");
a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
a_shut_dac_zero: assert property (shutdown |-> dac_code == 10'h000)
    else $error("code while shut");
a_sel_range: assert property (mux_select <= 4'h9)
    else $error("bad source");
a_enable_on: assert property (wr && paddr == 12'h000 && pwdata[0]
    |-> ##[1:2] !shutdown) else $error("enable lost");
a_disable_off: assert property (wr && paddr == 12'h000 && !pwdata[0]
    |-> ##[1:2] shutdown) else $error("no shutdown");
a_gain_half: assert property (wr && paddr == 12'h008 && pwdata[1:0] == 2'h0
    |-> ##[1:2] gain_half) else $error("gain not half");
cover property (pslverr);
cover property (gain_half && !shutdown);
cover property ($fell(dac_code == 10'h000));
endmodule
bind sac_top sac_props u_props (.*);

// File: test_sac_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: ideal comparator, input in steps of the 1x code
// Notes: results read over APB
`timescale 1ns/1ps
module test_sac_top;
reg sys_clk = 1'b0;
reg reset_n = 1'b0;
reg clk_en = 1'b1;
reg psel = 1'b0;
reg penable = 1'b0;
reg pwrite = 1'b0;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0;
reg [10:0] ain = 11'h000;
reg [31:0] rd;
reg err;
integer miscompares = 0, compares = 0, cyc = 0, i;
wire [31:0] prdata;
wire pready, pslverr, gain_half, shutdown;
wire [9:0] dac_code;
wire [3:0] mux_select;
// Half gain halves the input seen by the converter
wire [10:0] eff = gain_half ? {1'b0, ain[10:1]} : ain;
wire cmp_high = eff >= {1'b0, dac_code};
sac_top dut (.*);
initial forever #10 sys_clk = ~sys_clk;
task chk(input [31:0] got, input [31:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    end
endtask
task conv(input [10:0] v, input [31:0] h, input [31:0] l);
    integer n;
    begin
        ain <= v;
        apb(1, 12'h000, 32'h3);
        repeat (4) @(posedge sys_clk);
        rd = 32'h1;
        for (n = 0; n < 40 && rd[0]; n = n + 1)
            apb(0, 12'h014, 0);
        apb(0, 12'h00C, 0);
        chk(rd, h);
        apb(0, 12'h010, 0);
        chk(rd, l);
    end
endtask
task stop_test;
    begin
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
endtask
always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
        miscompares = miscompares + 1;
        stop_test;
    end
end
initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk(shutdown, 1);
    for (i = 0; i < 11; i = i + 1) begin
        apb(1, 12'h004, i);
        chk(mux_select, i < 10 ? i : 9);
    end
    $display("test select done");
    apb(1, 12'h008, 32'h1);
    conv(11'h200, 32'h80, 32'h0);
    conv(11'h3FF, 32'hFF, 32'hC0);
    apb(1, 12'h008, 32'h0);
    conv(11'h400, 32'h80, 32'h0);
    conv(11'h7FF, 32'hFF, 32'hC0);
    apb(1, 12'h008, 32'h5);
    conv(11'h3FF, 32'hFF, 32'h0);
    conv(11'h0C3, 32'h30, 32'h0);
    ain <= 11'h100;
    apb(1, 12'h000, 32'h2);
    repeat (30) @(posedge sys_clk);
    chk(dac_code, 0);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h30);
    apb(0, 12'h018, 0);
    chk(err, 1);
    chk(rd, 0);
    $display("test convert done");
    stop_test;
end
endmodule
